//--- logic/iep_defines.vh
// register map, field and reset constants for the interrupt enable and pending block
//
// Contract
// - Bit n of the upper enable-clear register stands for interrupt 32+n, covering interrupts 32 to 63.
// - A one written to an enable-clear bit disables that interrupt, and a zero leaves it alone.
// - A read of the enable-clear register returns each interrupt's enable state, one meaning enabled.
// - Bit n of the lower pending-set register stands for interrupt n, and a written one makes it pending.
// - A written pending-set one does nothing to an interrupt that is already pending or is disabled.
// - A read of the pending-set register returns the live pending state, one meaning pending.
// - A one written to a pending-clear bit clears that pending state, which then reads as zero.
// - A one written to an enable-set bit enables that interrupt, and a zero does nothing.
// - A pending-clear one has no effect on an interrupt whose handler is already in service.
`ifndef IEP_DEFINES_VH
`define IEP_DEFINES_VH

// word byte addresses
`define IEP_ADDR_EN_SET_LO 8'h00
`define IEP_ADDR_EN_SET_HI 8'h04
`define IEP_ADDR_EN_CLR_LO 8'h08
`define IEP_ADDR_EN_CLR_HI 8'h0c
`define IEP_ADDR_PEND_SET_LO 8'h10
`define IEP_ADDR_PEND_SET_HI 8'h14
`define IEP_ADDR_PEND_CLR_LO 8'h18
`define IEP_ADDR_PEND_CLR_HI 8'h1c
`define IEP_ADDR_IRQ_STATUS 8'h20
`define IEP_ADDR_IRQ_MASK 8'h24

// field layout
`define IEP_LO_MSB 31
`define IEP_HI_LSB 32
`define IEP_HI_MSB 63
`define IEP_ST_PEND_LO 0
`define IEP_ST_PEND_HI 1
`define IEP_ST_SET_DROP 2
`define IEP_ST_MSB 2

// reset values
`define IEP_RST_EN 64'h0000000000000000
`define IEP_RST_PEND 64'h0000000000000000
`define IEP_RST_WORD 32'h00000000
`define IEP_RST_ST 3'h0

`endif

//--- logic/iep_regs.v
// interrupt enable and pending registers with a status and mask event interrupt
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "iep_defines.vh"

module iep_regs #(
  parameter ADDR_W = 8
) (
  input wire REF_CLK_I,
  input wire RESET_I,
  input wire [ADDR_W-1:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  input wire [63:0] IRQ_REQ_I,
  input wire [63:0] IN_SERVICE_I,
  output wire [63:0] ENABLE_O,
  output wire [63:0] PENDING_O,
  output wire [63:0] REQUEST_O,
  output wire IRQ_O
);

  reg [63:0] enable;
  reg [63:0] pending;
  reg [63:0] req_meta;
  reg [63:0] req_sync;
  reg [63:0] req_prev;
  reg [`IEP_ST_MSB:0] irq_status;
  reg [`IEP_ST_MSB:0] irq_mask;
  reg [63:0] next_enable;
  reg [63:0] next_pending;
  reg [`IEP_ST_MSB:0] next_status;
  reg [31:0] next_rdata;
  reg [63:0] wr_en_set;
  reg [63:0] wr_en_clr;
  reg [63:0] wr_pend_set;
  reg [63:0] wr_pend_clr;
  wire [63:0] req_rise;
  wire [63:0] pend_set_eff;
  wire [63:0] pend_clr_eff;
  wire [63:0] pend_new;
  wire rd_status;

  // request lines come from peripherals, so two flops before use
  always @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      req_meta <= `IEP_RST_PEND;
      req_sync <= `IEP_RST_PEND;
      req_prev <= `IEP_RST_PEND;
    end
    else
    begin
      req_meta <= IRQ_REQ_I;
      req_sync <= req_meta;
      req_prev <= req_sync;
    end
  end

  assign req_rise = req_sync & ~req_prev;

  // decode writes into per-bit masks for each word
  always @*
  begin
    wr_en_set = 64'h0;
    wr_en_clr = 64'h0;
    wr_pend_set = 64'h0;
    wr_pend_clr = 64'h0;
    if (WR_I)
    begin
      case (ADDR_I)
        // enable-set low and high
        `IEP_ADDR_EN_SET_LO: wr_en_set[`IEP_LO_MSB:0] = WDATA_I;
        `IEP_ADDR_EN_SET_HI: wr_en_set[`IEP_HI_MSB:`IEP_HI_LSB] = WDATA_I;
        `IEP_ADDR_EN_CLR_LO: wr_en_clr[`IEP_LO_MSB:0] = WDATA_I;
        `IEP_ADDR_EN_CLR_HI: wr_en_clr[`IEP_HI_MSB:`IEP_HI_LSB] = WDATA_I;
        `IEP_ADDR_PEND_SET_LO: wr_pend_set[`IEP_LO_MSB:0] = WDATA_I;
        `IEP_ADDR_PEND_SET_HI: wr_pend_set[`IEP_HI_MSB:`IEP_HI_LSB] = WDATA_I;
        `IEP_ADDR_PEND_CLR_LO: wr_pend_clr[`IEP_LO_MSB:0] = WDATA_I;
        `IEP_ADDR_PEND_CLR_HI: wr_pend_clr[`IEP_HI_MSB:`IEP_HI_LSB] = WDATA_I;
        default: wr_en_set = 64'h0;
      endcase
    end
  end

  // ignore set when pending or disabled
  assign pend_set_eff = wr_pend_set & enable & ~pending;
  assign pend_clr_eff = wr_pend_clr & ~IN_SERVICE_I;
  // hardware requests pend only enabled lines
  assign pend_new = (req_rise & enable) | pend_set_eff;

  // enable and pending next state; set wins over clear
  always @*
  begin
    next_enable = enable;
    next_pending = pending;
    next_enable = next_enable | wr_en_set;
    next_enable = next_enable & ~(wr_en_clr & ~wr_en_set);
    next_pending = next_pending & ~pend_clr_eff;
    next_pending = next_pending | pend_new;
  end

  assign rd_status = RD_I && (ADDR_I == `IEP_ADDR_IRQ_STATUS);

  // sticky events; a read clears but a new event in that cycle wins
  always @*
  begin
    next_status = irq_status;
    if (rd_status)
      next_status = `IEP_RST_ST;
    next_status[`IEP_ST_PEND_LO] = next_status[`IEP_ST_PEND_LO] | (|pend_new[`IEP_LO_MSB:0]);
    next_status[`IEP_ST_PEND_HI] = next_status[`IEP_ST_PEND_HI] | (|pend_new[`IEP_HI_MSB:`IEP_HI_LSB]);
    next_status[`IEP_ST_SET_DROP] = next_status[`IEP_ST_SET_DROP] | (|(wr_pend_set & ~pend_set_eff));
  end

  // read mux, data lands one cycle after the strobe
  always @*
  begin
    next_rdata = `IEP_RST_WORD;
    if (RD_I)
    begin
      case (ADDR_I)
        `IEP_ADDR_EN_SET_LO: next_rdata = enable[`IEP_LO_MSB:0];
        `IEP_ADDR_EN_SET_HI: next_rdata = enable[`IEP_HI_MSB:`IEP_HI_LSB];
        `IEP_ADDR_EN_CLR_LO: next_rdata = enable[`IEP_LO_MSB:0];
        `IEP_ADDR_EN_CLR_HI: next_rdata = enable[`IEP_HI_MSB:`IEP_HI_LSB];
        `IEP_ADDR_PEND_SET_LO: next_rdata = pending[`IEP_LO_MSB:0];
        `IEP_ADDR_PEND_SET_HI: next_rdata = pending[`IEP_HI_MSB:`IEP_HI_LSB];
        `IEP_ADDR_PEND_CLR_LO: next_rdata = pending[`IEP_LO_MSB:0];
        `IEP_ADDR_PEND_CLR_HI: next_rdata = pending[`IEP_HI_MSB:`IEP_HI_LSB];
        `IEP_ADDR_IRQ_STATUS: next_rdata = {29'h0, irq_status};
        `IEP_ADDR_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        default: next_rdata = `IEP_RST_WORD; // unmapped reads zero
      endcase
    end
  end

  // state registers
  always @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      enable <= `IEP_RST_EN;
      pending <= `IEP_RST_PEND;
      irq_status <= `IEP_RST_ST;
      irq_mask <= `IEP_RST_ST;
      RDATA_O <= `IEP_RST_WORD;
    end
    else
    begin
      enable <= next_enable;
      pending <= next_pending;
      irq_status <= next_status;
      if (WR_I && (ADDR_I == `IEP_ADDR_IRQ_MASK))
        irq_mask <= WDATA_I[`IEP_ST_MSB:0];
      RDATA_O <= next_rdata;
    end
  end

  assign ENABLE_O = enable;
  assign PENDING_O = pending;
  // only enabled, pending and not in service goes to the core
  assign REQUEST_O = pending & enable & ~IN_SERVICE_I;
  assign IRQ_O = |(irq_status & irq_mask);

endmodule // iep_regs

//--- testbench/iep_core.sv
// core model that takes requests into service
`timescale 1ns/100ps
module iep_core (
  input wire clk_i,
  input wire take_i,
  input wire [63:0] request_i,
  output reg [63:0] in_service_o
);
  // service held while take_i is high so clears can hit it
  initial in_service_o = 64'h0;
  always @(posedge clk_i)
  begin
    in_service_o <= take_i ? in_service_o | request_i : 64'h0;
  end
endmodule // iep_core

//--- testbench/iep_regs_assertions.sv
// assertions on the enable and pending register ports
`timescale 1ns/100ps
module iep_chk (
  input wire REF_CLK_I,
  input wire RESET_I,
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [31:0] RDATA_O,
  input wire [63:0] IN_SERVICE_I,
  input wire [63:0] ENABLE_O,
  input wire [63:0] PENDING_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  // low word pending writes decoded once
  wire ps = WR_I && ADDR_I == 8'h10;
  wire pc = WR_I && ADDR_I == 8'h18;
  wire [31:0] pl = PENDING_O[31:0];
  AST_EN_CLR: assert property (WR_I && ADDR_I == 8'h0c |=> !(ENABLE_O[63:32] & $past(WDATA_I)))
    else $error("enable clear missed");
  AST_EN_SET: assert property (WR_I && ADDR_I == 8'h00 |=> &(ENABLE_O[31:0] | ~$past(WDATA_I)))
    else $error("enable set missed");
  AST_RD_EN: assert property (RD_I && ADDR_I == 8'h0c |=> RDATA_O == $past(ENABLE_O[63:32]))
    else $error("enable read wrong");
  AST_RD_PEND: assert property (RD_I && ADDR_I == 8'h10 |=> RDATA_O == $past(pl))
    else $error("pending read wrong");
  AST_PEND_SET: assert property (ps |=> &(pl | ~($past(WDATA_I) & $past(ENABLE_O[31:0]))))
    else $error("pending set missed");
  AST_PEND_GATE: assert property (ps |=> !(pl & ~$past(pl) & ~$past(ENABLE_O[31:0])))
    else $error("disabled bit pended");
  AST_PEND_CLR: assert property (pc |=> !(pl & $past(WDATA_I) & ~$past(IN_SERVICE_I[31:0])))
    else $error("pending clear missed");
  AST_IN_SVC: assert property (pc |=> &(pl | ~($past(pl) & $past(IN_SERVICE_I[31:0]))))
    else $error("in service bit cleared");
endmodule // iep_chk
bind iep_regs iep_chk u_chk (.REF_CLK_I, .RESET_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
  .IN_SERVICE_I, .ENABLE_O, .PENDING_O);

//--- testbench/iep_regs_tb.sv
// self-checking bench for the enable and pending registers
`timescale 1ns/100ps
module iep_regs_tb;
  reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, take = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg [63:0] irq_req = 64'h0;
  wire [31:0] rdata;
  wire [63:0] en, pend, req, serv;
  wire irq;
  integer fail_count = 0, n_tests = 0, cyc = 0;
  // request lines held low until the last scenario raises two of them
  iep_regs dut (.REF_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .IRQ_REQ_I(irq_req), .IN_SERVICE_I(serv), .ENABLE_O(en), .PENDING_O(pend),
    .REQUEST_O(req), .IRQ_O(irq));
  iep_core core (.clk_i(clk), .take_i(take), .request_i(req), .in_service_o(serv));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      fail_count = fail_count + 1;
    end
  end
  endtask
  // one-cycle strobes, then settle past the edge before checking
  task wr_reg(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  end
  endtask
  task rd_reg(input [7:0] a, input [31:0] exp);
  begin
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // hang guard, the run needs about 50 cycles
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h0c, 32'h0);
    rd_reg(8'h10, 32'h0);
    wr_reg(8'h00, 32'hffff0001);
    wr_reg(8'h04, 32'h0000ffff);
    wr_reg(8'h0c, 32'h00000101);
    rd_reg(8'h0c, 32'h0000fefe);
    chk(en[63:32], 32'h0000fefe);
    rd_reg(8'h08, 32'hffff0001);
    wr_reg(8'h24, 32'h1);
    wr_reg(8'h10, 32'h0001000f);
    chk({31'h0, irq}, 32'h1);
    chk(pend[31:0], 32'h00010001);
    rd_reg(8'h10, 32'h00010001);
    rd_reg(8'h20, 32'h5);
    chk({31'h0, irq}, 32'h0);
    wr_reg(8'h10, 32'h1);
    take <= 1'b1;
    wr_reg(8'h18, 32'h00010001);
    rd_reg(8'h10, 32'h00010001);
    take <= 1'b0;
    wr_reg(8'h18, 32'h1);
    rd_reg(8'h10, 32'h00010000);
    chk(req[31:0], 32'h00010000);
    rd_reg(8'h40, 32'h0);
    irq_req <= 64'h0000000300000000;
    repeat (4) @(posedge clk);
    #1;
    chk(pend[63:32], 32'h2);
    chk(req[63:32], 32'h2);
    rd_reg(8'h20, 32'h6);
    wrap_up;
  end
endmodule // iep_regs_tb
